// >>> verilog/ssx_cfg.svh
/*
  Constants for the subtract/swap/xor datapath: opcode patterns,
  field positions, reset values and register addresses.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SSX_CFG_SVH
`define SSX_CFG_SVH

// ---------------------------------------------------------------
// Instruction fields
// ---------------------------------------------------------------
`define SSX_DEST_BIT 7
`define SSX_FADDR_MSB 6
`define SSX_LIT_MSB 7
`define SSX_DIR_SEL_MSB 2

// ---------------------------------------------------------------
// Opcode patterns
// ---------------------------------------------------------------
`define SSX_OP_LIT_SUB 5'h1E
`define SSX_OP_LIT_XOR 6'h3A
`define SSX_OP_FILE_SUB 6'h02
`define SSX_OP_SWAP 6'h0E
`define SSX_OP_FILE_XOR 6'h06
`define SSX_OP_DIR_LOAD 11'h00C
`define SSX_DIR_SEL_LO 3'h5
`define SSX_DIR_SEL_HI 3'h7

// ---------------------------------------------------------------
// Addresses and reset values
// ---------------------------------------------------------------
`define SSX_TIMER_ADDR 7'h01
`define SSX_ACC_RESET 8'h00
`define SSX_DIR_RESET 8'hFF
`define SSX_NOP_CYCLES 2'h1

`endif

// >>> verilog/ssx_pkg.sv
/*
  Types shared by the subtract/swap/xor datapath.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ssx_pkg;
  // Decoded operation
  typedef enum logic [2:0] {
    SSX_OP_NONE = 3'h0,
    SSX_OP_LSUB = 3'h1,
    SSX_OP_FSUB = 3'h2,
    SSX_OP_SWAP = 3'h3,
    SSX_OP_LXOR = 3'h4,
    SSX_OP_FXOR = 3'h5,
    SSX_OP_DIRL = 3'h6
  } ssx_op_t;

  // Execution phase: issue, then a no-operation slot
  typedef enum logic [0:0] {
    SSX_PH_RUN = 1'h0,
    SSX_PH_NOP = 1'h1
  } ssx_phase_t;
endpackage

// >>> verilog/ssx_decode.sv
/*
  Instruction decoder for the subtract/swap/xor datapath.
  Assumes a 14-bit instruction word from the same clock domain.
*/
`include "ssx_cfg.svh"

module ssx_decode (
  input wire logic [13:0] instr,
  output ssx_pkg::ssx_op_t op,
  output logic dir_valid
);
  // ---------------------------------------------------------------
  // Pattern match on the upper opcode bits
  // ---------------------------------------------------------------
  always_comb
  begin
    op = ssx_pkg::SSX_OP_NONE;
    dir_valid = 1'b0;
    if (instr[13:9] == `SSX_OP_LIT_SUB)
      op = ssx_pkg::SSX_OP_LSUB;
    else if (instr[13:8] == `SSX_OP_LIT_XOR)
      op = ssx_pkg::SSX_OP_LXOR;
    else if (instr[13:8] == `SSX_OP_FILE_SUB)
      op = ssx_pkg::SSX_OP_FSUB;
    else if (instr[13:8] == `SSX_OP_SWAP)
      op = ssx_pkg::SSX_OP_SWAP;
    else if (instr[13:8] == `SSX_OP_FILE_XOR)
      op = ssx_pkg::SSX_OP_FXOR;
    else if (instr[13:3] == `SSX_OP_DIR_LOAD)
    begin
      op = ssx_pkg::SSX_OP_DIRL;
      // Selector outside 5..7 is decoded but does nothing
      dir_valid = (instr[2:0] >= `SSX_DIR_SEL_LO) &&
                  (instr[2:0] <= `SSX_DIR_SEL_HI);
    end
  end
endmodule

// >>> verilog/ssx_flags.sv
/*
  Result and flag arithmetic for the subtract/swap/xor datapath.
  Assumes operands settled combinationally in the same cycle.
*/
module ssx_flags (
  input wire logic [7:0] minuend,
  input wire logic [7:0] acc,
  output logic [7:0] diff,
  output logic carry,
  output logic half_carry,
  output logic zero_sub
);
  logic [8:0] full;
  logic [4:0] low;

  // ---------------------------------------------------------------
  // Subtract as add of complement plus one, carry is not-borrow
  // ---------------------------------------------------------------
  always_comb
  begin
    full = {1'b0, minuend} + {1'b0, ~acc} + 9'h001;
    low = {1'b0, minuend[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    diff = full[7:0];
    carry = full[8];
    half_carry = low[4];
    zero_sub = (full[7:0] == 8'h00);
  end
endmodule

// >>> verilog/ssx_alu.sv
/*
  Execution datapath for literal/file subtract, nibble exchange,
  literal/file exclusive-or and the legacy direction load.
  Assumes the core fetches a new word each enabled cycle, supplies
  the addressed file register value and the pin levels for it, and
  performs the file write using the write port outputs here.
*/
// Local design decisions: the placing of the registers and the plain strobed port.
`include "ssx_cfg.svh"

module ssx_alu (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic pc_change,
  input wire logic [7:0] file_latch,
  input wire logic [7:0] file_pins,
  input wire logic file_is_io,
  input wire logic presc_on_timer,
  output logic [7:0] acc,
  output logic carry,
  output logic half_carry,
  output logic zero,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic presc_clear,
  output logic [7:0] dir_5,
  output logic [7:0] dir_6,
  output logic [7:0] dir_7,
  output logic busy
);
  // ---------------------------------------------------------------
  // Decode and arithmetic
  // ---------------------------------------------------------------
  ssx_pkg::ssx_op_t op;
  ssx_pkg::ssx_phase_t phase;
  ssx_pkg::ssx_phase_t next_phase;
  logic dir_valid;
  logic [7:0] operand;
  logic [7:0] minuend;
  logic [7:0] diff;
  logic sub_c;
  logic sub_dc;
  logic sub_z;
  logic [7:0] result;
  logic dest_file;
  logic [6:0] faddr;
  logic [7:0] next_acc;
  logic next_carry;
  logic next_half_carry;
  logic next_zero;
  logic next_file_we;
  logic [7:0] next_file_wdata;
  logic [6:0] next_file_waddr;
  logic next_presc_clear;
  logic [7:0] dir_q [5:7];
  logic [7:0] next_dir [5:7];
  logic issue;

  ssx_decode u_decode (
    .instr(instr),
    .op(op),
    .dir_valid(dir_valid)
  );

  // File operand: pins for I/O registers, else the stored value
  assign operand = file_is_io ? file_pins : file_latch;
  assign faddr = instr[`SSX_FADDR_MSB:0];
  assign dest_file = instr[`SSX_DEST_BIT];
  assign minuend = (op == ssx_pkg::SSX_OP_LSUB) ?
                   instr[`SSX_LIT_MSB:0] : operand;

  ssx_flags u_flags (
    .minuend(minuend),
    .acc(acc),
    .diff(diff),
    .carry(sub_c),
    .half_carry(sub_dc),
    .zero_sub(sub_z)
  );

  // Only issue on a fresh word; the no-operation slot swallows it
  assign issue = instr_valid && (phase == ssx_pkg::SSX_PH_RUN);

  // ---------------------------------------------------------------
  // Phase: a program-counter change holds one extra dead cycle
  // ---------------------------------------------------------------
  always_comb
  begin
    next_phase = ssx_pkg::SSX_PH_RUN;
    unique case (phase)
      ssx_pkg::SSX_PH_RUN:
        if (instr_valid && pc_change)
          next_phase = ssx_pkg::SSX_PH_NOP;
      ssx_pkg::SSX_PH_NOP:
        next_phase = ssx_pkg::SSX_PH_RUN;
    endcase
  end

  // ---------------------------------------------------------------
  // Result, routing and flag updates
  // ---------------------------------------------------------------
  always_comb
  begin
    next_acc = acc;
    next_carry = carry;
    next_half_carry = half_carry;
    next_zero = zero;
    next_file_we = 1'b0;
    next_file_wdata = file_wdata;
    next_file_waddr = file_waddr;
    next_presc_clear = 1'b0;
    for (int i = 5; i <= 7; i++)
      next_dir[i] = dir_q[i];
    result = 8'h00;
    if (issue)
    begin
      unique case (op)
        ssx_pkg::SSX_OP_LSUB,
        ssx_pkg::SSX_OP_FSUB:
        begin
          result = diff;
          next_carry = sub_c;
          next_half_carry = sub_dc;
          next_zero = sub_z;
        end
        ssx_pkg::SSX_OP_SWAP:
          result = {operand[3:0], operand[7:4]};
        ssx_pkg::SSX_OP_LXOR:
        begin
          result = acc ^ instr[`SSX_LIT_MSB:0];
          next_zero = (result == 8'h00);
        end
        ssx_pkg::SSX_OP_FXOR:
        begin
          result = acc ^ operand;
          next_zero = (result == 8'h00);
        end
        ssx_pkg::SSX_OP_DIRL:
          if (dir_valid)
            next_dir[instr[2:0]] = acc;
        ssx_pkg::SSX_OP_NONE:
          result = 8'h00;
      endcase
      // Literal forms always land in the accumulator
      if (op == ssx_pkg::SSX_OP_LSUB || op == ssx_pkg::SSX_OP_LXOR)
        next_acc = result;
      else if (op == ssx_pkg::SSX_OP_FSUB ||
               op == ssx_pkg::SSX_OP_SWAP ||
               op == ssx_pkg::SSX_OP_FXOR)
      begin
        if (dest_file)
        begin
          next_file_we = 1'b1;
          next_file_waddr = faddr;
          next_file_wdata = result;
          // Writing the timer count resets the shared prescaler when presc_on_timer is set
          if (faddr == `SSX_TIMER_ADDR && presc_on_timer)
            next_presc_clear = 1'b1;
        end
        else
          next_acc = result;
      end
    end
  end

  // ---------------------------------------------------------------
  // State registers, frozen while the clock enable is low
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase <= ssx_pkg::SSX_PH_RUN;
      acc <= `SSX_ACC_RESET;
      carry <= 1'b0;
      half_carry <= 1'b0;
      zero <= 1'b0;
      file_we <= 1'b0;
      file_waddr <= 7'h00;
      file_wdata <= 8'h00;
      presc_clear <= 1'b0;
      busy <= 1'b0;
      for (int i = 5; i <= 7; i++)
        dir_q[i] <= `SSX_DIR_RESET;
    end
    else if (ce)
    begin
      phase <= next_phase;
      acc <= next_acc;
      carry <= next_carry;
      half_carry <= next_half_carry;
      zero <= next_zero;
      file_we <= next_file_we;
      file_waddr <= next_file_waddr;
      file_wdata <= next_file_wdata;
      presc_clear <= next_presc_clear;
      busy <= (next_phase == ssx_pkg::SSX_PH_NOP);
      for (int i = 5; i <= 7; i++)
        dir_q[i] <= next_dir[i];
    end
  end

  // Direction registers leave straight from their flip-flops
  assign dir_5 = dir_q[5];
  assign dir_6 = dir_q[6];
  assign dir_7 = dir_q[7];
endmodule

// >>> verification/ssx_alu_props.sv
/*
  Assertions for the subtract/swap/xor datapath.
  Assumes binding to ssx_alu; sees its ports only.
*/
module ssx_alu_props (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [13:0] instr,
  input wire logic instr_valid,
  input wire logic pc_change,
  input wire logic [7:0] file_latch,
  input wire logic [7:0] file_pins,
  input wire logic file_is_io,
  input wire logic presc_on_timer,
  input wire logic [7:0] acc,
  input wire logic carry,
  input wire logic half_carry,
  input wire logic zero,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  input wire logic presc_clear,
  input wire logic [7:0] dir_6,
  input wire logic busy
);
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  logic take;
  logic [7:0] opnd;
  logic [7:0] swp;
  logic [7:0] lit;
  logic [6:0] fa;
  // Word accepted at this edge; operand read as pins for I/O
  assign take = ce && instr_valid && !busy;
  assign opnd = file_is_io ? file_pins : file_latch;
  assign swp = {opnd[3:0], opnd[7:4]};
  assign lit = instr[7:0];
  assign fa = instr[6:0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------
  // Properties
  // ---------------------------------------------------------
  presc_clr_a: assert property (
    take && instr[13:7] == 7'h05 && fa == 7'h01 && presc_on_timer
    |=> presc_clear) else $error("prescaler not cleared");
  nop_slot_a: assert property (
    take && pc_change |=> busy ##1 !busy)
    else $error("no single dead cycle");
  nop_hold_a: assert property (
    busy |=> $stable(acc) && !file_we)
    else $error("word taken in dead cycle");
  lit_sub_a: assert property (
    take && instr[13:9] == 5'h1E |=>
    acc == $past(lit) - $past(acc) && carry == ($past(lit) >= $past(acc)))
    else $error("literal subtract wrong");
  file_sub_a: assert property (
    take && instr[13:7] == 7'h04 |=>
    acc == $past(opnd) - $past(acc) && half_carry == ($past(swp[7:4])
    >= $past(acc[3:0]))) else $error("file subtract wrong");
  swap_dest_a: assert property (
    take && instr[13:7] == 7'h1D |=>
    file_we && file_wdata == $past(swp) && file_waddr == $past(fa)
    && $stable(zero)) else $error("nibble exchange wrong");
  lit_xor_a: assert property (
    take && instr[13:8] == 6'h3A |=>
    acc == ($past(lit) ^ $past(acc)) && zero == (acc == 8'h00)
    && $stable(carry)) else $error("literal xor wrong");
  file_xor_a: assert property (
    take && instr[13:7] == 7'h0C |=>
    acc == ($past(opnd) ^ $past(acc)) && $stable(half_carry))
    else $error("file xor wrong");
  dir_load_a: assert property (
    take && instr == 14'h0066 |=>
    dir_6 == $past(acc)) else $error("direction load wrong");
  cover property (take && pc_change);
  cover property (presc_clear);
  cover property (take && file_is_io && instr[13:8] == 6'h0E);
endmodule

// >>> verification/ssx_alu_tb.sv
/*
  Self-checking bench for the subtract/swap/xor datapath.
  Assumes ssx_alu and its checker are compiled before it.
*/
module ssx_alu_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Word, file value, then acc, write data, {c,hc,z,we,clr}
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0] lat;
    logic [7:0] acc;
    logic [7:0] wd;
    logic [4:0] fl;
  } ssx_row_t;
  logic mclk, rst_b, ce, instr_valid, pc_change, file_is_io;
  logic presc_on_timer, carry, half_carry, zero, file_we;
  logic presc_clear, busy;
  logic [13:0] instr;
  logic [7:0] file_latch, file_pins, acc, file_wdata;
  logic [7:0] dir_5, dir_6, dir_7;
  logic [6:0] file_waddr;
  int error_cnt, num_checks;
  ssx_row_t rows [18];
  ssx_alu uut (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .instr(instr),
    .instr_valid(instr_valid),
    .pc_change(pc_change),
    .file_latch(file_latch),
    .file_pins(file_pins),
    .file_is_io(file_is_io),
    .presc_on_timer(presc_on_timer),
    .acc(acc),
    .carry(carry),
    .half_carry(half_carry),
    .zero(zero),
    .file_we(file_we),
    .file_waddr(file_waddr),
    .file_wdata(file_wdata),
    .presc_clear(presc_clear),
    .dir_5(dir_5),
    .dir_6(dir_6),
    .dir_7(dir_7),
    .busy(busy)
  );
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic issue(input logic [13:0] w, input logic [7:0] lat);
    @(posedge mclk);
    instr <= w;
    file_latch <= lat;
    instr_valid <= 1'b1;
  endtask
  // Drop the request at the taking edge, then look once it lands
  task automatic settle();
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task automatic row_chk(input ssx_row_t r);
    check({acc, carry, half_carry, zero, file_we, presc_clear},
      {r.acc, r.fl});
    if (r.fl[1])
      check(file_wdata, r.wd);
  endtask
  task automatic reset_chk();
    check({acc, dir_5, dir_6, dir_7, carry, half_carry, zero, busy},
      36'h00FFFFFF0);
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Generous bound: the sequence needs well under 100 cycles
  initial
  begin
    #2000;
    error_cnt++;
    close_out();
  end
  // ---------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------
  initial
  begin
    {rst_b, instr_valid, pc_change, file_is_io, instr} = '0;
    {file_latch, file_pins} = '0;
    {ce, presc_on_timer} = 2'b11;
    rows = '{'{14'h3A02,8'h00,8'h02,8'h00,5'h00},
      '{14'h3C05,8'h00,8'h03,8'h00,5'h18},
      '{14'h3C03,8'h00,8'h00,8'h00,5'h1C},
      '{14'h3A02,8'h00,8'h02,8'h00,5'h18},
      '{14'h3C01,8'h00,8'hFF,8'h00,5'h00},
      '{14'h3AFD,8'h00,8'h02,8'h00,5'h00},
      '{14'h0281,8'h03,8'h02,8'h01,5'h1B},
      '{14'h0205,8'h02,8'h00,8'h00,5'h1C},
      '{14'h3C00,8'h00,8'h00,8'h00,5'h1C},
      '{14'h3CFF,8'h00,8'hFF,8'h00,5'h18},
      '{14'h0E85,8'hA5,8'hFF,8'h5A,5'h1A},
      '{14'h0E05,8'hA5,8'h5A,8'h00,5'h18},
      '{14'h0685,8'h5A,8'h5A,8'h00,5'h1E},
      '{14'h0601,8'h0F,8'h55,8'h00,5'h18},
      '{14'h0E81,8'h12,8'h55,8'h21,5'h1B},
      '{14'h0201,8'h10,8'hBB,8'h00,5'h00},
      '{14'h3C1F,8'h00,8'h64,8'h00,5'h08},
      '{14'h0066,8'h00,8'h64,8'h00,5'h08}};
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    #1 reset_chk();
    // Back to back words, each checked at the edge after it
    for (int i = 0; i < 18; i++)
    begin
      issue(rows[i].ins, rows[i].lat);
      if (i > 0)
        #1 row_chk(rows[i - 1]);
    end
    settle();
    row_chk(rows[17]);
    check({dir_5, dir_6, dir_7}, 24'hFF64FF);
    // Legacy direction load kept to these words; selector 4 is ignored
    issue(14'h0064, 8'h00);
    issue(14'h0067, 8'h00);
    settle();
    check({dir_5, dir_6, dir_7, acc}, 32'hFF646464);
    // I/O register operand comes from the pins, not the latch
    issue(14'h0E05, 8'hF0);
    file_is_io <= 1'b1;
    file_pins <= 8'h0F;
    settle();
    check({acc, carry, half_carry, zero}, 11'h782);
    // Branch-type word: the next offered word must be dropped
    issue(14'h3A0F, 8'h00);
    pc_change <= 1'b1;
    file_is_io <= 1'b0;
    issue(14'h3A0F, 8'h00);
    pc_change <= 1'b0;
    #1 check({acc, busy}, 9'h1FF);
    settle();
    check({acc, busy}, 9'h1FE);
    // Top file address, and timer write with prescaler elsewhere
    issue(14'h02FF, 8'h00);
    settle();
    check({file_we, presc_clear, file_waddr, file_wdata, carry},
      18'h2FE02);
    issue(14'h0281, 8'h00);
    presc_on_timer <= 1'b0;
    settle();
    check({file_we, presc_clear}, 2'h2);
    // Clock enable low: an offered word must leave all state frozen
    issue(14'h3A55, 8'h00);
    ce <= 1'b0;
    settle();
    check({acc, file_we, busy}, 10'h3FC);
    // Reset in mid-run restores every register
    @(posedge mclk);
    rst_b <= 1'b0;
    ce <= 1'b1;
    #1 reset_chk();
    @(posedge mclk);
    rst_b <= 1'b1;
    close_out();
  end
endmodule
bind ssx_alu ssx_alu_props u_props (
  .mclk(mclk),
  .rst_b(rst_b),
  .ce(ce),
  .instr(instr),
  .instr_valid(instr_valid),
  .pc_change(pc_change),
  .file_latch(file_latch),
  .file_pins(file_pins),
  .file_is_io(file_is_io),
  .presc_on_timer(presc_on_timer),
  .acc(acc),
  .carry(carry),
  .half_carry(half_carry),
  .zero(zero),
  .file_we(file_we),
  .file_waddr(file_waddr),
  .file_wdata(file_wdata),
  .presc_clear(presc_clear),
  .dir_6(dir_6),
  .busy(busy)
);
